// ===== logic/dflc_top.sv
`default_nettype none
module dflc_top
  import dflc_pkg::*;
(
  // clock and restart
  input wire logic SYS_CLK,
  input wire logic NRST,
  // fault causes from detection logic, same clock
  input wire dflc_pkg::dflc_vec_t FAULT_CAUSE,
  // alarm-reset digital input pin, asynchronous
  input wire logic ALARM_RESET_INPUT,
  // special-function parameter write strobe and value
  input wire logic SPECIAL_FUNCTION_PARAM_WE,
  input wire logic [7:0] SPECIAL_FUNCTION_PARAM,
  // latched alarms
  output logic [DFLC_N-1:0] ALARM_LATCHED,
  output logic ALARM_ANY
);
  import dflc_pkg::*;

  // ==========================================================
  // pin synchroniser and edge of the alarm-reset input
  logic rstin_s1_q, rstin_s2_q, rstin_s3_q;
  // the edge logic reads only the second and third stages, never the first
  wire rstin_pulse = rstin_s2_q & ~rstin_s3_q;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rstin_s1_q <= 1'b0;
      rstin_s2_q <= 1'b0;
      rstin_s3_q <= 1'b0;
    end else begin
      rstin_s1_q <= ALARM_RESET_INPUT;
      rstin_s2_q <= rstin_s1_q;
      rstin_s3_q <= rstin_s2_q;
    end
  end

  // ==========================================================
  // firmware-upgrade unlock sequence; a restart returns it to idle, so
  // the armed fact is copied into a sticky flag that survives the restart
  dflc_seq_e seq_q, seq_d;
  always_comb begin
    seq_d = seq_q;
    if (SPECIAL_FUNCTION_PARAM_WE) begin
      unique case (seq_q)
        DFLC_IDLE: seq_d = (SPECIAL_FUNCTION_PARAM == DFLC_KEY1) ? DFLC_GOT1 : DFLC_IDLE;
        DFLC_GOT1: seq_d = (SPECIAL_FUNCTION_PARAM == DFLC_KEY2) ? DFLC_ARMED :
                           (SPECIAL_FUNCTION_PARAM == DFLC_KEY1) ? DFLC_GOT1 : DFLC_IDLE;
        DFLC_ARMED: seq_d = DFLC_ARMED;
        default: seq_d = DFLC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sticky latches that a restart must not touch, power-on value from the declaration; fw_restart_q is reset by restart
  logic rsvd_q = 1'b0;
  logic fw_q = 1'b0;
  logic fw_armed_q = 1'b0;
  logic fw_restart_q;
  // fw_restart_q is low while restart is held and in the first cycle after it
  wire fw_clr = fw_armed_q & ~fw_restart_q;
  wire rsvd_d = rsvd_q | FAULT_CAUSE[A_RSVD];
  // set wins over clear: a cause still present at restart relatches
  wire fw_d = (fw_q & ~fw_clr) | FAULT_CAUSE[A_FW_UPG];
  wire fw_armed_d = ~fw_clr & (fw_armed_q | (seq_q == DFLC_ARMED));

  always_ff @(posedge SYS_CLK) begin
    rsvd_q <= rsvd_d;
    fw_q <= fw_d;
    fw_armed_q <= fw_armed_d;
  end

  // ==========================================================
  // alarm latch; restart clears every slot held here
  dflc_vec_t alarm_q, alarm_d, lat_w;
  wire dflc_vec_t rst_rel = rstin_pulse ? DFLC_RST_OK : DFLC_RESET_VAL;
  wire dflc_vec_t auto_rel = DFLC_AUTO_OK & ~FAULT_CAUSE;

  always_comb begin
    alarm_d = (alarm_q & ~rst_rel & ~auto_rel) | FAULT_CAUSE;
    // these two slots live in the sticky latches above
    alarm_d[A_RSVD] = 1'b0;
    alarm_d[A_FW_UPG] = 1'b0;
  end

  always_comb begin
    lat_w = alarm_q;
    lat_w[A_RSVD] = rsvd_q;
    lat_w[A_FW_UPG] = fw_q;
  end

  // restart clears the non-sticky alarms
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      alarm_q <= DFLC_RESET_VAL;
      seq_q <= DFLC_IDLE;
      fw_restart_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      seq_q <= seq_d;
      fw_restart_q <= 1'b1;
    end
  end

  assign ALARM_LATCHED = lat_w;
  assign ALARM_ANY = |lat_w;

  // ==========================================================
  rsvd_sticky_a: assert property (@(posedge SYS_CLK)
    rsvd_q |=> rsvd_q) else $error("reserved alarm released");
  fw_clear_a: assert property (@(posedge SYS_CLK)
    fw_clr && !FAULT_CAUSE[A_FW_UPG] |=> !fw_q) else $error("fw alarm not released");
  phase_pin_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rstin_pulse && !FAULT_CAUSE[A_PHASE] |=> !alarm_q[A_PHASE]) else $error("phase reset ignored");
  restart_only_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    alarm_q[A_ENC_MAG] |=> alarm_q[A_ENC_MAG]) else $error("restart-only alarm dropped");
  prot_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    alarm_q[A_MOT_PROT] && !rstin_pulse |=> alarm_q[A_MOT_PROT]) else $error("protection alarm lost");
  prot_clear_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rstin_pulse && !FAULT_CAUSE[A_MOT_PROT] |=> !alarm_q[A_MOT_PROT]) else $error("reset ignored");
  temp_auto_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !FAULT_CAUSE[A_TEMP_WARN] |=> !alarm_q[A_TEMP_WARN]) else $error("warning stuck");
  ser_auto_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !FAULT_CAUSE[A_SER_ERR] |=> !alarm_q[A_SER_ERR]) else $error("link error stuck");
  tmo_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    alarm_q[A_SER_TMO] && !rstin_pulse |=> alarm_q[A_SER_TMO]) else $error("timeout auto cleared");
  phase_auto_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !FAULT_CAUSE[A_PHASE] |=> !alarm_q[A_PHASE]) else $error("phase alarm stuck");
  relatch_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    FAULT_CAUSE[A_MOT_PROT] |=> alarm_q[A_MOT_PROT]) else $error("cause not relatched");
  fw_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    fw_q && !fw_armed_q |=> fw_q) else $error("fw alarm early");
endmodule
`default_nettype wire

// ===== logic/dflc_pkg.sv
`default_nettype none
package dflc_pkg;
  // ==========================================================
  // alarm slot positions in the latched alarm vector
  localparam int unsigned DFLC_N = 17;
  localparam int unsigned A_SER_ERR = 0;
  localparam int unsigned A_SER_TMO = 1;
  localparam int unsigned A_RSVD = 2;
  localparam int unsigned A_PHASE = 3;
  localparam int unsigned A_PREOVL = 4;
  localparam int unsigned A_ENC_MAG = 5;
  localparam int unsigned A_ENC_INT = 6;
  localparam int unsigned A_ENC_DAT = 7;
  localparam int unsigned A_MOT_INT = 8;
  localparam int unsigned A_WIRING = 9;
  localparam int unsigned A_MOT_TEMP = 10;
  localparam int unsigned A_MOT_PROT = 11;
  localparam int unsigned A_ENC_OUT = 12;
  localparam int unsigned A_TEMP_WARN = 13;
  localparam int unsigned A_FW_UPG = 14;
  localparam int unsigned A_SPARE0 = 15;
  localparam int unsigned A_SPARE1 = 16;
  typedef logic [DFLC_N-1:0] dflc_vec_t;
  // ==========================================================
  // clearing classes: reset-input may release, cause-gone may release
  localparam dflc_vec_t DFLC_RST_OK = 17'h0181b;
  localparam dflc_vec_t DFLC_AUTO_OK = 17'h02009;
  localparam dflc_vec_t DFLC_RESET_VAL = 17'h00000;
  // special-function parameter unlock values
  localparam logic [7:0] DFLC_KEY1 = 8'h1e;
  localparam logic [7:0] DFLC_KEY2 = 8'h1c;
  typedef enum logic [1:0] {DFLC_IDLE, DFLC_GOT1, DFLC_ARMED} dflc_seq_e;
endpackage
`default_nettype wire

// ===== tb/dflc_partner.sv
`default_nettype none
// ==========
// operator side: special-function parameter unlock writes
module dflc_partner (
  // clock and command from the bench
  input wire logic clk,
  input wire logic unlock,
  // parameter write toward the block
  output logic we,
  output logic [7:0] val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step_q = 2'h0;
  initial we = 1'b0;
  initial val = 8'h00;
  // a released bus inverts its value every cycle, so the last written value shows again every other cycle
  // the command is taken on the rising edge, where the bench holds it steady
  always @(posedge clk) begin
    step_q <= (step_q != 2'h0) ? step_q + 2'h1 : {1'b0, unlock};
  end
  always @(negedge clk) begin
    we <= step_q[1] ^ step_q[0];
    val <= (step_q == 2'h1) ? 8'h1e : (step_q == 2'h2) ? 8'h1c : ~val;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dflc_pkg::*;
  logic SYS_CLK = 1'b0, NRST = 1'b0, rst_pin = 1'b0, unlock = 1'b0, we, any;
  logic [7:0] val;
  dflc_vec_t cause = '0;
  logic [DFLC_N-1:0] lat;
  int errors = 0, check_count = 0, cyc = 0;
  dflc_top u_dflc_top(.SYS_CLK(SYS_CLK), .NRST(NRST), .FAULT_CAUSE(cause), .ALARM_RESET_INPUT(rst_pin),
    .SPECIAL_FUNCTION_PARAM_WE(we), .SPECIAL_FUNCTION_PARAM(val), .ALARM_LATCHED(lat), .ALARM_ANY(any));
  dflc_partner u_dflc_partner(.clk(SYS_CLK), .unlock(unlock), .we(we), .val(val));
  initial forever #2 SYS_CLK = ~SYS_CLK;
  task automatic tick(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic pulse_rst;
    rst_pin = 1'b1;
    tick(3);
    rst_pin = 1'b0;
    tick(4);
  endtask
  task automatic restart;
    NRST = 1'b0;
    tick(1);
    NRST = 1'b1;
    tick(2);
  endtask
  // ==========
  // scenarios
  task automatic auto_clear;
    cause = 17'h02009;
    tick(2);
    `CHK("auto set", 17'h02009, lat)
    `CHK("any", 1'b1, any)
    cause = '0;
    tick(2);
    `CHK("auto gone", 17'h00000, lat)
  endtask
  task automatic pin_clear;
    cause = 17'h01ff6;
    tick(2);
    cause = 17'h00804;
    pulse_rst();
    `CHK("pin held cause", 17'h00fe4, lat)
    cause = 17'h00004;
    pulse_rst();
    `CHK("pin release", 17'h007e4, lat)
  endtask
  task automatic restart_clear;
    restart();
    `CHK("restart", 17'h00004, lat)
  endtask
  task automatic fw_clear;
    cause = 17'h04004;
    tick(2);
    cause = 17'h00004;
    pulse_rst();
    `CHK("fw pin refused", 17'h04004, lat)
    unlock = 1'b1;
    tick(1);
    unlock = 1'b0;
    tick(4);
    restart();
    `CHK("fw unlocked", 17'h00004, lat)
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // the whole run needs about 60 cycles
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    tick(20);
    NRST = 1'b1;
    tick(2);
    auto_clear();
    pin_clear();
    restart_clear();
    fw_clear();
    finish_test();
  end
endmodule
`default_nettype wire
